// file: logic/bwdc_pkg.sv
// package: register map, field positions, reset values and states of the bus watch data comparator
package bwdc_pkg;

	// bus widths of the watched processor buses and of the register port, and the trace depth
	localparam int BUS_ADDR_W  = 18;
	localparam int BUS_DATA_W  = 16;
	localparam int AV_ADDR_W   = 10;
	localparam int TRACE_DEPTH = 8;

	// register indexes; byte address on the register port is four times the index
	localparam logic [7:0] REG_CTL1_IDX     = 8'h20;
	localparam logic [7:0] REG_STATUS_IDX   = 8'h21;
	localparam logic [7:0] REG_IRQ_ST_IDX   = 8'h22;
	localparam logic [7:0] REG_IRQ_MSK_IDX  = 8'h23;
	localparam logic [7:0] REG_TRACE_IDX    = 8'h24;
	localparam logic [7:0] REG_CMP_CTL_IDX  = 8'h28;
	localparam logic [7:0] REG_ADDR_HI_IDX  = 8'h29;
	localparam logic [7:0] REG_ADDR_MID_IDX = 8'h2a;
	localparam logic [7:0] REG_ADDR_LO_IDX  = 8'h2b;
	localparam logic [7:0] REG_DATA_HI_IDX  = 8'h2c;
	localparam logic [7:0] REG_DATA_LO_IDX  = 8'h2d;
	localparam logic [7:0] REG_DMASK_HI_IDX = 8'h2e;
	localparam logic [7:0] REG_DMASK_LO_IDX = 8'h2f;

	// debug_control_one fields
	localparam int CTL1_ARM_BIT   = 7;
	localparam int CTL1_FORCE_BIT = 6;
	localparam int CTL1_BRK_BIT   = 4;
	localparam int CTL1_TRACE_BIT = 3;
	localparam int CTL1_VIEW_LSB  = 0;

	// comparator_view_select codes
	localparam logic [1:0] VIEW_A    = 2'h0;
	localparam logic [1:0] VIEW_B    = 2'h1;
	localparam logic [1:0] VIEW_C    = 2'h2;
	localparam logic [1:0] VIEW_NONE = 2'h3;

	// comparator control fields (comparator_a_control and its siblings)
	localparam int CC_EN_BIT  = 0;
	localparam int CC_RW_BIT  = 2;
	localparam int CC_RWE_BIT = 3;
	localparam int CC_SZ_BIT  = 4;
	localparam int CC_TAG_BIT = 5;
	localparam int CC_SZE_BIT = 6;

	// interrupt status and mask layout
	localparam int IRQ_W         = 3;
	localparam int IRQ_FINAL_BIT = 0;
	localparam int IRQ_BRK_BIT   = 1;
	localparam int IRQ_FULL_BIT  = 2;

	// reset values
	localparam logic [7:0]            CTL1_RST    = 8'h00;
	localparam logic [7:0]            CMP_CTL_RST = 8'h00;
	localparam logic [BUS_ADDR_W-1:0] ADDR_RST    = 18'h00000;
	localparam logic [7:0]            DATA_RST    = 8'h00;
	localparam logic [7:0]            MASK_RST    = 8'h00;
	localparam logic [IRQ_W-1:0]      IRQ_RST     = 3'h0;

	// state sequencer states
	typedef enum logic [2:0] {
		BWDC_IDLE  = 3'b001,
		BWDC_ARMED = 3'b010,
		BWDC_FINAL = 3'b100
	} bwdc_state_e;

endpackage : bwdc_pkg

// file: logic/bwdc_comparator.sv
// module: one address comparator with optional data, direction, size and tag qualification
`timescale 1ns/1ps
module bwdc_comparator import bwdc_pkg::*; #(
	parameter bit HAS_DATA = 1'b0,
	parameter bit HAS_SIZE = 1'b0
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset,
	// comparator setup
	input  wire logic [7:0]            ctl,
	input  wire logic [BUS_ADDR_W-1:0] cmp_addr,
	input  wire logic [BUS_DATA_W-1:0] cmp_data,
	input  wire logic [BUS_DATA_W-1:0] cmp_mask,
	// watched bus
	input  wire logic                  bus_valid,
	input  wire logic [BUS_ADDR_W-1:0] bus_addr,
	input  wire logic [BUS_DATA_W-1:0] bus_data,
	input  wire logic                  bus_read,
	input  wire logic                  bus_byte,
	input  wire logic                  bus_fetch,
	input  wire logic                  exec_valid,
	input  wire logic                  exec_discard,
	input  wire logic                  inhibit,
	// result
	output logic                       hit
);

	logic raw_hit;
	logic rw_ok;
	logic size_ok;
	logic data_ok;
	logic forced_hit;
	logic tag_set;
	logic tag_pend_ff;

	// address match, blocked while the debug monitor owns the bus
	assign raw_hit = bus_valid && !inhibit && ctl[CC_EN_BIT] && (bus_addr == cmp_addr);
	assign rw_ok   = !ctl[CC_RWE_BIT] || (ctl[CC_RW_BIT] == bus_read);
	assign size_ok = !HAS_SIZE || !ctl[CC_SZE_BIT] || (ctl[CC_SZ_BIT] == bus_byte);
	// only comparator A looks at data; a zero mask bit lets that bit float
	assign data_ok = !HAS_DATA || (((bus_data ^ cmp_data) & cmp_mask) == '0);
	// forced match fires in the same cycle as the bus; tagging ignores data and access type
	assign forced_hit = raw_hit && !ctl[CC_TAG_BIT] && rw_ok && size_ok && data_ok;
	assign tag_set    = raw_hit && ctl[CC_TAG_BIT] && bus_fetch;

	// tag tracking: one pending opcode, dropped if the queue throws it away
	always_ff @(posedge clock) begin
		if (reset) begin
			tag_pend_ff <= 1'b0;
		end else if (tag_set) begin
			tag_pend_ff <= 1'b1; // set wins over a discard in the same cycle
		end else if (exec_discard || (exec_valid && !inhibit) || !ctl[CC_TAG_BIT]) begin
			tag_pend_ff <= 1'b0;
		end
	end

	assign hit = forced_hit || (tag_pend_ff && exec_valid && !exec_discard && !inhibit);

	tag_discard_a: assert property (@(posedge clock) disable iff (reset)
		(exec_discard && !tag_set) |=> !tag_pend_ff)
		else $error("discarded tagged opcode still produced a hit");

endmodule : bwdc_comparator

// file: logic/bwdc_sequencer.sv
// module: state sequencer that reaches the final state on a match or a software force
`timescale 1ns/1ps
module bwdc_sequencer import bwdc_pkg::*; (
	// clock and reset
	input  wire logic  clock,
	input  wire logic  reset,
	// control
	input  wire logic  armed,
	input  wire logic  match,
	input  wire logic  force_final,
	input  wire logic  brk_en,
	input  wire logic  trace_en,
	input  wire logic  secure,
	// results
	output bwdc_state_e state_ff,
	output logic       final_pulse_ff,
	output logic       brk_pulse_ff,
	output logic       trace_start_ff
);

	bwdc_state_e nxt_state;
	logic        enter_final;

	// transitions; nothing leaves idle unless armed, and disarming returns to idle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			BWDC_IDLE:  nxt_state = armed ? BWDC_ARMED : BWDC_IDLE;
			BWDC_ARMED: begin
				if (!armed) begin
					nxt_state = BWDC_IDLE;
				end else if (match || force_final) begin
					nxt_state = BWDC_FINAL;
				end
			end
			BWDC_FINAL: nxt_state = armed ? BWDC_FINAL : BWDC_IDLE;
			default:    nxt_state = BWDC_IDLE;
		endcase
	end

	assign enter_final = (state_ff == BWDC_ARMED) && (nxt_state == BWDC_FINAL);

	// state and final-state actions; secure mode keeps breakpoints but no tracing
	always_ff @(posedge clock) begin
		if (reset) begin
			state_ff       <= BWDC_IDLE;
			final_pulse_ff <= 1'b0;
			brk_pulse_ff   <= 1'b0;
			trace_start_ff <= 1'b0;
		end else begin
			state_ff       <= nxt_state;
			final_pulse_ff <= enter_final;
			brk_pulse_ff   <= enter_final && brk_en;
			trace_start_ff <= enter_final && trace_en && !secure;
		end
	end

	force_final_a: assert property (@(posedge clock) disable iff (reset)
		(state_ff == BWDC_ARMED && armed && force_final) |=> (state_ff == BWDC_FINAL) ##0 final_pulse_ff)
		else $error("force did not reach the final state");
	secure_trace_a: assert property (@(posedge clock) disable iff (reset)
		$past(secure) |-> !trace_start_ff)
		else $error("tracing started in secure mode");

endmodule : bwdc_sequencer

// file: logic/bwdc_top.sv
// module: bus watch data comparator with registers on an Avalon-MM slave
//
// How it works
// - each data value bit says whether its data bus bit must be zero or one
// - a value bit counts only where the same mask bit is one
// - two masks cover bits 15..8 and 7..0; zero ignores, one compares
// - data comparison happens only while the comparator A tag bit is clear
// - data registers read only with view 00, written only then and unarmed
// - only comparator A has data registers; B and C never compare data
// - secure mode keeps breakpoints but stops all tracing
// - the arm bit enables sequencer triggering, trace storage and breakpoints
// - every comparator watches the address bus; A also watches masked data
// - matches may be qualified by read/write direction, and on comparator B only by word/byte size
// - a forced match moves the sequencer in the same cycle as the bus
// - a tagged match moves the sequencer only when its opcode executes
// - entering the final state starts tracing and/or raises a breakpoint
// - writing the force bit jumps to the final state, with breakpoint if enabled
// - the trace window is two bytes wide and answers only 16-bit reads
// - the view field picks comparator A, B, C or none in the shared window
// - comparators are blocked in background debug mode and its accesses
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module bwdc_top import bwdc_pkg::*; #(
	parameter int DEPTH = TRACE_DEPTH
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset,
	// register port
	input  wire logic [AV_ADDR_W-1:0]  avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// watched processor buses
	input  wire logic                  bus_valid,
	input  wire logic [BUS_ADDR_W-1:0] bus_addr,
	input  wire logic [BUS_DATA_W-1:0] bus_data,
	input  wire logic                  bus_read,
	input  wire logic                  bus_byte,
	input  wire logic                  bus_fetch,
	input  wire logic                  exec_valid,
	input  wire logic                  exec_discard,
	// chip state
	input  wire logic                  background_debug_mode,
	input  wire logic                  debug_access,
	input  wire logic                  secure,
	// results
	output logic                       cpu_break,
	output logic                       irq
);

	localparam int PTR_W = $clog2(DEPTH);

	// one byte of an 18-bit comparator address, by lane
	function automatic logic [7:0] addr_byte(input logic [BUS_ADDR_W-1:0] a, input logic [1:0] lane);
		logic [23:0] wide;
		wide = {6'h00, a};
		addr_byte = wide[lane*8 +: 8];
	endfunction : addr_byte

	////////////////////////////////////////////////////////////////////////////////
	// register port decode

	logic [7:0]            idx;
	logic                  wr_take;
	logic                  rd_take;
	logic                  lane0;
	logic [7:0]            wbyte;
	logic                  avs_waitrequest_ff;
	logic [31:0]           avs_readdata_ff;
	logic [31:0]           nxt_readdata;
	logic [7:0]            ctl1_ff;
	logic                  armed;
	logic [1:0]            view;
	logic [1:0]            view_slot;
	logic                  view_ok;
	logic                  force_pulse_ff;
	logic [7:0]            cmp_ctl_ff  [0:2];
	logic [BUS_ADDR_W-1:0] cmp_addr_ff [0:2];
	logic [7:0]            data_hi_ff;
	logic [7:0]            data_lo_ff;
	logic [7:0]            mask_hi_ff;
	logic [7:0]            mask_lo_ff;
	logic [IRQ_W-1:0]      irq_st_ff;
	logic [IRQ_W-1:0]      irq_msk_ff;
	logic [IRQ_W-1:0]      irq_evt;
	logic                  irq_ff;
	logic                  cpu_break_ff;

	assign idx       = avs_address[9:2];
	assign wr_take   = avs_write && !avs_waitrequest_ff;
	assign rd_take   = avs_read && !avs_waitrequest_ff;
	assign lane0     = avs_byteenable[0];
	assign wbyte     = avs_writedata[7:0];
	assign armed     = ctl1_ff[CTL1_ARM_BIT];
	assign view      = ctl1_ff[CTL1_VIEW_LSB +: 2];
	assign view_ok   = (view != VIEW_NONE);
	assign view_slot = view_ok ? view : VIEW_A;

	// one wait cycle per request: the answer comes on the second edge
	always_ff @(posedge clock) begin
		if (reset) begin
			avs_waitrequest_ff <= 1'b1;
		end else begin
			avs_waitrequest_ff <= !((avs_read || avs_write) && avs_waitrequest_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register and software force

	always_ff @(posedge clock) begin
		if (reset) begin
			ctl1_ff        <= CTL1_RST;
			force_pulse_ff <= 1'b0;
		end else begin
			force_pulse_ff <= 1'b0;
			if (wr_take && lane0 && idx == REG_CTL1_IDX) begin
				ctl1_ff        <= {wbyte[7], 1'b0, wbyte[5:0]}; // force bit never reads back
				force_pulse_ff <= wbyte[CTL1_FORCE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// comparator setup through the shared window; locked while armed

	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < 3; i++) begin
				cmp_ctl_ff[i]  <= CMP_CTL_RST;
				cmp_addr_ff[i] <= ADDR_RST;
			end
		end else if (wr_take && lane0 && view_ok && !armed) begin
			case (idx)
				REG_CMP_CTL_IDX:  cmp_ctl_ff[view_slot]         <= wbyte;
				REG_ADDR_HI_IDX:  cmp_addr_ff[view_slot][17:16] <= wbyte[1:0];
				REG_ADDR_MID_IDX: cmp_addr_ff[view_slot][15:8]  <= wbyte;
				REG_ADDR_LO_IDX:  cmp_addr_ff[view_slot][7:0]   <= wbyte;
				default:          ;
			endcase
		end
	end

	// data value and masks: comparator A only, view A and unarmed
	always_ff @(posedge clock) begin
		if (reset) begin
			data_hi_ff <= DATA_RST;
			data_lo_ff <= DATA_RST;
			mask_hi_ff <= MASK_RST;
			mask_lo_ff <= MASK_RST;
		end else if (wr_take && lane0 && view == VIEW_A && !armed) begin
			case (idx)
				REG_DATA_HI_IDX:  data_hi_ff <= wbyte;
				REG_DATA_LO_IDX:  data_lo_ff <= wbyte;
				REG_DMASK_HI_IDX: mask_hi_ff <= wbyte;
				REG_DMASK_LO_IDX: mask_lo_ff <= wbyte;
				default:          ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// comparators and sequencer

	logic [2:0]  cmp_hit;
	logic        inhibit;
	bwdc_state_e seq_state;
	logic        final_pulse;
	logic        brk_pulse;
	logic        trace_start;

	assign inhibit = background_debug_mode || debug_access;

	for (genvar g = 0; g < 3; g++) begin : g_cmp
		bwdc_comparator #(
			.HAS_DATA (g == 0),
			.HAS_SIZE (g == 1)
		) u_cmp (
			.clock        (clock),
			.reset        (reset),
			.ctl          (cmp_ctl_ff[g]),
			.cmp_addr     (cmp_addr_ff[g]),
			.cmp_data     ({data_hi_ff, data_lo_ff}),
			.cmp_mask     ({mask_hi_ff, mask_lo_ff}),
			.bus_valid    (bus_valid),
			.bus_addr     (bus_addr),
			.bus_data     (bus_data),
			.bus_read     (bus_read),
			.bus_byte     (bus_byte),
			.bus_fetch    (bus_fetch),
			.exec_valid   (exec_valid),
			.exec_discard (exec_discard),
			.inhibit      (inhibit),
			.hit          (cmp_hit[g])
		);
	end

	bwdc_sequencer u_seq (
		.clock          (clock),
		.reset          (reset),
		.armed          (armed),
		.match          (|cmp_hit),
		.force_final    (force_pulse_ff),
		.brk_en         (ctl1_ff[CTL1_BRK_BIT]),
		.trace_en       (ctl1_ff[CTL1_TRACE_BIT]),
		.secure         (secure),
		.state_ff       (seq_state),
		.final_pulse_ff (final_pulse),
		.brk_pulse_ff   (brk_pulse),
		.trace_start_ff (trace_start)
	);

	// breakpoint to the processor, only while armed
	always_ff @(posedge clock) begin
		if (reset) begin
			cpu_break_ff <= 1'b0;
		end else begin
			cpu_break_ff <= brk_pulse && armed;
		end
	end
	assign cpu_break = cpu_break_ff;

	////////////////////////////////////////////////////////////////////////////////
	// trace store and 16-bit read window

	logic [BUS_DATA_W-1:0] trace_mem [0:DEPTH-1];
	logic                  tracing_ff;
	logic [PTR_W:0]        trace_cnt_ff;
	logic [PTR_W-1:0]      trace_wp_ff;
	logic [PTR_W-1:0]      trace_rp_ff;
	logic                  trace_full;
	logic                  trace_push;
	logic                  trace_pop;
	logic                  trace_word_rd;

	assign trace_full    = (trace_cnt_ff == (PTR_W+1)'(DEPTH));
	// secure mode or disarm stops storage at once; tracing only follows the final state
	assign trace_push    = tracing_ff && armed && !secure && bus_valid && !inhibit && !trace_full;
	assign trace_word_rd = (avs_byteenable[1:0] == 2'h3); // byte reads get zero and do not advance
	assign trace_pop     = rd_take && idx == REG_TRACE_IDX && trace_word_rd && trace_cnt_ff != '0;

	always_ff @(posedge clock) begin
		if (reset) begin
			tracing_ff <= 1'b0;
		end else if (trace_start) begin
			tracing_ff <= 1'b1;
		end else if (!armed || secure || trace_full) begin
			tracing_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			trace_wp_ff  <= '0;
			trace_rp_ff  <= '0;
			trace_cnt_ff <= '0;
		end else begin
			if (trace_push) begin
				trace_wp_ff <= trace_wp_ff + 1'b1;
			end
			if (trace_pop) begin
				trace_rp_ff <= trace_rp_ff + 1'b1;
			end
			trace_cnt_ff <= trace_cnt_ff + (PTR_W+1)'(trace_push) - (PTR_W+1)'(trace_pop);
		end
	end

	always_ff @(posedge clock) begin
		if (trace_push) begin
			trace_mem[trace_wp_ff] <= bus_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky status, write one to clear, set wins

	assign irq_evt = {trace_push && (trace_cnt_ff == (PTR_W+1)'(DEPTH-1)), brk_pulse && armed, final_pulse};

	always_ff @(posedge clock) begin
		if (reset) begin
			irq_st_ff  <= IRQ_RST;
			irq_msk_ff <= IRQ_RST;
		end else begin
			if (wr_take && lane0 && idx == REG_IRQ_MSK_IDX) begin
				irq_msk_ff <= wbyte[IRQ_W-1:0];
			end
			if (wr_take && lane0 && idx == REG_IRQ_ST_IDX) begin
				irq_st_ff <= (irq_st_ff & ~wbyte[IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_st_ff <= irq_st_ff | irq_evt;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_st_ff & irq_msk_ff);
		end
	end
	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////////
	// read data; unmapped and hidden registers read zero

	always_comb begin
		nxt_readdata = 32'h00000000;
		case (idx)
			REG_CTL1_IDX:     nxt_readdata[7:0] = ctl1_ff;
			REG_STATUS_IDX:   nxt_readdata[7:0] = {1'b0, tracing_ff, trace_full, 2'h0, seq_state};
			REG_IRQ_ST_IDX:   nxt_readdata[IRQ_W-1:0] = irq_st_ff;
			REG_IRQ_MSK_IDX:  nxt_readdata[IRQ_W-1:0] = irq_msk_ff;
			REG_TRACE_IDX:    nxt_readdata[15:0] = trace_word_rd ? trace_mem[trace_rp_ff] : 16'h0000;
			REG_CMP_CTL_IDX:  nxt_readdata[7:0] = view_ok ? cmp_ctl_ff[view_slot] : 8'h00;
			REG_ADDR_HI_IDX:  nxt_readdata[7:0] = view_ok ? addr_byte(cmp_addr_ff[view_slot], 2'h2) : 8'h00;
			REG_ADDR_MID_IDX: nxt_readdata[7:0] = view_ok ? addr_byte(cmp_addr_ff[view_slot], 2'h1) : 8'h00;
			REG_ADDR_LO_IDX:  nxt_readdata[7:0] = view_ok ? addr_byte(cmp_addr_ff[view_slot], 2'h0) : 8'h00;
			REG_DATA_HI_IDX:  nxt_readdata[7:0] = (view == VIEW_A) ? data_hi_ff : 8'h00;
			REG_DATA_LO_IDX:  nxt_readdata[7:0] = (view == VIEW_A) ? data_lo_ff : 8'h00;
			REG_DMASK_HI_IDX: nxt_readdata[7:0] = (view == VIEW_A) ? mask_hi_ff : 8'h00;
			REG_DMASK_LO_IDX: nxt_readdata[7:0] = (view == VIEW_A) ? mask_lo_ff : 8'h00;
			default:          nxt_readdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			avs_readdata_ff <= 32'h00000000;
		end else if (avs_read && avs_waitrequest_ff) begin
			avs_readdata_ff <= nxt_readdata; // stands with waitrequest low
		end
	end

	assign avs_readdata    = avs_readdata_ff;
	assign avs_waitrequest = avs_waitrequest_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence armed_write_s;
		wr_take && lane0 && armed && idx[7:2] == REG_DATA_HI_IDX[7:2];
	endsequence

	sequence data_hit_s;
		bus_valid && !inhibit && cmp_ctl_ff[0][CC_EN_BIT] && !cmp_ctl_ff[0][CC_TAG_BIT]
			&& !cmp_ctl_ff[0][CC_RWE_BIT] && bus_addr == cmp_addr_ff[0];
	endsequence

	data_lock_a: assert property (@(posedge clock) disable iff (reset)
		armed_write_s |=> $stable({data_hi_ff, data_lo_ff, mask_hi_ff, mask_lo_ff}))
		else $error("data register changed while armed");
	view_hidden_a: assert property (@(posedge clock) disable iff (reset)
		(rd_take && idx[7:2] == REG_DATA_HI_IDX[7:2] && view != VIEW_A) |=> (avs_readdata[7:0] == 8'h00))
		else $error("mask visible outside view A");
	data_mask_a: assert property (@(posedge clock) disable iff (reset)
		data_hit_s |-> ((((bus_data ^ {data_hi_ff, data_lo_ff}) & {mask_hi_ff, mask_lo_ff}) == 16'h0000) == cmp_hit[0]))
		else $error("comparator A data result wrong");
	debug_block_a: assert property (@(posedge clock) disable iff (reset)
		inhibit |-> (cmp_hit == 3'h0))
		else $error("comparator hit during background debug");
	brk_armed_a: assert property (@(posedge clock) disable iff (reset)
		cpu_break |-> $past(armed))
		else $error("breakpoint while unarmed");
	forced_same_a: assert property (@(posedge clock) disable iff (reset)
		(seq_state == BWDC_ARMED && armed && (|cmp_hit)) |=> (seq_state == BWDC_FINAL))
		else $error("forced match did not move sequencer next edge");
	final_brk_a: assert property (@(posedge clock) disable iff (reset)
		(final_pulse && ctl1_ff[CTL1_BRK_BIT] && $past(ctl1_ff[CTL1_BRK_BIT]) && armed) |=> cpu_break)
		else $error("final state gave no breakpoint");
	secure_store_a: assert property (@(posedge clock) disable iff (reset)
		secure |=> $stable(trace_wp_ff))
		else $error("trace stored in secure mode");
	byte_read_a: assert property (@(posedge clock) disable iff (reset)
		(rd_take && idx == REG_TRACE_IDX && !trace_word_rd) |=> $stable(trace_rp_ff))
		else $error("byte read advanced trace window");

endmodule : bwdc_top

// file: bench/bwdc_bus_model.sv
// model of the processor buses that the comparators watch
`timescale 1ns/1ps
module bwdc_bus_model import bwdc_pkg::*; (
	// clock
	input  wire logic                  clock,
	// watched processor buses
	output logic                       bus_valid,
	output logic [BUS_ADDR_W-1:0]      bus_addr,
	output logic [BUS_DATA_W-1:0]      bus_data,
	output logic                       bus_read,
	output logic                       bus_byte,
	output logic                       bus_fetch,
	output logic                       exec_valid,
	output logic                       exec_discard
);
	// quiet bus: word writes, no fetches, no execution events
	initial begin
		{bus_valid, bus_read, bus_byte, bus_fetch, exec_valid, exec_discard} = 6'h00;
		bus_addr = '0;
		bus_data = '0;
	end
	// one word write cycle; idle lines show the inverse so a stale value never matches
	task automatic cyc(input logic [BUS_ADDR_W-1:0] a, input logic [BUS_DATA_W-1:0] d);
		bus_valid <= 1'b1;
		bus_addr  <= a;
		bus_data  <= d;
		@(posedge clock);
		bus_valid <= 1'b0;
		bus_addr  <= ~a;
		bus_data  <= ~d;
		@(posedge clock);
	endtask : cyc
	// opcode fetch at a, then the queue either discards it or executes it
	task automatic fetch_op(input logic [BUS_ADDR_W-1:0] a, input logic drop);
		bus_valid <= 1'b1;
		bus_fetch <= 1'b1;
		bus_addr  <= a;
		@(posedge clock);
		bus_valid    <= 1'b0;
		bus_fetch    <= 1'b0;
		bus_addr     <= ~a;
		exec_discard <= drop;
		exec_valid   <= ~drop;
		@(posedge clock);
		exec_discard <= 1'b0;
		exec_valid   <= 1'b0;
		@(posedge clock);
	endtask : fetch_op
endmodule : bwdc_bus_model

// file: bench/bwdc_top_tb.sv
// register and bus-match scenarios for the bus watch data comparator
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module bwdc_top_tb import bwdc_pkg::*; ;
	logic                  clock, reset, avs_read, avs_write, avs_waitrequest, cpu_break, irq;
	logic                  bus_valid, bus_read, bus_byte, bus_fetch, exec_valid, exec_discard;
	logic                  background_debug_mode, debug_access, secure;
	logic [AV_ADDR_W-1:0]  avs_address;
	logic [3:0]            avs_byteenable = 4'hf;
	logic [31:0]           avs_writedata, avs_readdata, q;
	logic [BUS_ADDR_W-1:0] bus_addr;
	logic [BUS_DATA_W-1:0] bus_data;
	int                    err_count = 0, samples_checked = 0, brk_n = 0;
	////////////////////////////////////////////////////////////////////////////////
	bwdc_top #(.DEPTH(8)) bwdc_top_inst (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_valid, .bus_addr, .bus_data, .bus_read,
		.bus_byte, .bus_fetch, .exec_valid, .exec_discard, .background_debug_mode, .debug_access, .secure,
		.cpu_break, .irq);
	bwdc_bus_model bwdc_bus_model_inst (.clock, .bus_valid, .bus_addr, .bus_data, .bus_read, .bus_byte,
		.bus_fetch, .exec_valid, .exec_discard);
	// clock and breakpoint pulse counter
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) if (cpu_break === 1'b1) brk_n++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// one Avalon transfer; held until waitrequest is sampled low, bounded wait
	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		n = 0;
		avs_address   <= {i, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write     <= w;
		avs_read      <= ~w;
		do begin
			@(posedge clock);
			n++;
			if (n > 40) begin
				err_count++;
				wrap_up();
			end
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge clock);
	endtask : acc
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		acc(1'b1, i, d);
	endtask : wr
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		acc(1'b0, i, 8'h00);
		`CHK(q, e)
	endtask : rd
	// bus cycle on comparator A's address, then room for the two-edge breakpoint lag
	task automatic hit(input logic [15:0] d, input int e);
		bwdc_bus_model_inst.cyc(18'h01234, d);
		repeat (4) @(posedge clock);
		`CHK(brk_n, e)
	endtask : hit
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{reset, avs_read, avs_write, background_debug_mode, debug_access, secure} = 6'h20;
		avs_address = '0;
		avs_writedata = '0;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		for (int i = 8'h2c; i <= 8'h2f; i++) rd(i[7:0], 32'h0);
		rd(8'h3f, 32'h0);
		wr(8'h2c, 8'h5a);
		wr(8'h2d, 8'hc3);
		wr(8'h2e, 8'hff);
		wr(8'h2f, 8'h0f);
		rd(8'h2d, 32'hc3);
		wr(8'h20, 8'h01);
		rd(8'h2c, 32'h0);
		wr(8'h2c, 8'h11);
		wr(8'h20, 8'h00);
		rd(8'h2c, 32'h5a);
		wr(8'h28, 8'h01);
		wr(8'h2a, 8'h12);
		wr(8'h2b, 8'h34);
		hit(16'h5ab3, 0);
		wr(8'h20, 8'h90);
		wr(8'h2d, 8'h00);
		rd(8'h2d, 32'hc3);
		background_debug_mode <= 1'b1;
		hit(16'h5ab3, 0);
		background_debug_mode <= 1'b0;
		hit(16'h5bc3, 0);
		hit(16'h5ab3, 1);
		rd(8'h21, 32'h04);
		rd(8'h22, 32'h03);
		wr(8'h23, 8'h01);
		@(posedge clock);
		`CHK(irq, 1'b1)
		wr(8'h22, 8'h01);
		repeat (2) @(posedge clock);
		`CHK(irq, 1'b0)
		wr(8'h22, 8'h02);
		// tagged: a discarded fetch and a plain data match give nothing, an executed fetch breaks
		wr(8'h20, 8'h00);
		wr(8'h28, 8'h21);
		wr(8'h20, 8'h90);
		bwdc_bus_model_inst.fetch_op(18'h01234, 1'b1);
		hit(16'h5ab3, 1);
		bwdc_bus_model_inst.fetch_op(18'h01234, 1'b0);
		repeat (4) @(posedge clock);
		`CHK(brk_n, 2)
		// force with breakpoints off, then twice with tracing: secure first
		wr(8'h20, 8'h00);
		wr(8'h20, 8'h80);
		wr(8'h20, 8'hc0);
		rd(8'h21, 32'h04);
		`CHK(brk_n, 2)
		for (int s = 1; s >= 0; s--) begin
			secure <= s[0];
			wr(8'h22, 8'h07);
			wr(8'h20, 8'h00);
			wr(8'h20, 8'h88);
			wr(8'h20, 8'hc8);
			repeat (2) @(posedge clock); // storage starts two edges after the force lands
			for (int k = 0; k < 8; k++) bwdc_bus_model_inst.cyc(18'h00100, 16'h0100 + 16'(k));
			rd(8'h22, s ? 32'h01 : 32'h05);
		end
		avs_byteenable <= 4'h1;
		rd(8'h24, 32'h0);
		avs_byteenable <= 4'hf;
		rd(8'h24, 32'h0100);
		rd(8'h24, 32'h0101);
		wrap_up();
	end
endmodule : bwdc_top_tb
